// file: smieg_consts.vh
`ifndef SMIEG_CONSTS_VH
`define SMIEG_CONSTS_VH

// Register offsets within the power management I/O block.
`define SMIEG_ADDR_W          5
`define SMIEG_OFF_STATUS_TWO  5'h13
`define SMIEG_OFF_ENABLE_ONE  5'h14
`define SMIEG_OFF_ENABLE_TWO  5'h15
`define SMIEG_OFF_MISC_STATUS 5'h16

// Reset values.
`define SMIEG_RST_BYTE        8'h00

// Second status register fields.
`define SMIEG_S2_MOUSE        0
`define SMIEG_S2_KEYBOARD     1
`define SMIEG_S2_INFRARED     2
`define SMIEG_S2_SECONDARY    3
`define SMIEG_S2_KBC_PORT     4
`define SMIEG_S2_SLEEP        7

// First enable register fields.
`define SMIEG_E1_RING         0
`define SMIEG_E1_PARALLEL     1
`define SMIEG_E1_SERIAL_TWO   2
`define SMIEG_E1_SERIAL_ONE   3
`define SMIEG_E1_FLOPPY       4
`define SMIEG_E1_GROUP_B      5
`define SMIEG_E1_GROUP_A      6
`define SMIEG_E1_WATCHDOG     7

// Second enable register fields.
`define SMIEG_E2_MOUSE        0
`define SMIEG_E2_KEYBOARD     1
`define SMIEG_E2_INFRARED     2
`define SMIEG_E2_SECONDARY    3
`define SMIEG_E2_KBC_ROUTE    4
`define SMIEG_E2_CONSUMER_IR  5
`define SMIEG_E2_TO_WAKE      6
`define SMIEG_E2_DRIVE        7

// Miscellaneous status fields.
`define SMIEG_MS_EDGE_LSB     0
`define SMIEG_MS_EDGE_MSB     3
`define SMIEG_MS_STANDBY      4
`define SMIEG_EDGE_INPUTS     4

`endif

// file: smieg_edge_sync.v
`default_nettype none

module smieg_edge_sync
#(
   parameter WIDTH = 4
)
(
   input  wire             clk_sys,   // System clock.
   input  wire             resetn,    // Asynchronous reset, active low.
   input  wire [WIDTH-1:0] pinIn,     // Raw inputs.
   output reg  [WIDTH-1:0] pinSync,   // Synchronised level.
   output wire [WIDTH-1:0] pinChange  // One-cycle pulse on either edge.
);

   reg [WIDTH-1:0] stageOne;
   reg [WIDTH-1:0] pinLast;

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         stageOne <= {WIDTH{1'b0}};
         pinSync  <= {WIDTH{1'b0}};
         pinLast  <= {WIDTH{1'b0}};
      end
      else
      begin
         stageOne <= pinIn;
         pinSync  <= stageOne;
         pinLast  <= pinSync;
      end
   end

   // A change between two consecutive synchronised samples is an edge.
   assign pinChange = pinSync ^ pinLast;

endmodule

`default_nettype wire

// file: smieg_group_irq.v
`include "smieg_consts.vh"
`default_nettype none

module smieg_group_irq
(
   input  wire       clk_sys,          // System clock, 25 MHz.
   input  wire       resetn,           // Asynchronous reset, active low.
   input  wire [4:0] ioAddr,           // Offset within the I/O block.
   input  wire       ioRd,             // Read strobe, one cycle.
   input  wire       ioWr,             // Write strobe, one cycle.
   input  wire [7:0] ioWrData,         // Write data.
   output reg  [7:0] ioRdData,         // Read data, valid after strobe.
   input  wire       mouseIrq,         // Mouse interrupt level.
   input  wire       keyboardIrq,      // Keyboard interrupt level.
   input  wire       kbcPortBit,       // Keyboard controller port bit.
   input  wire       serialTwoRxIn,    // Serial two receive pin.
   input  wire       infraredRxIn,     // Infrared receive pin.
   input  wire       irRxSelect,       // Receive mux: 1 picks infrared pin.
   input  wire       secondaryEvent,   // Secondary event pulse.
   input  wire       sleepRequestSmi,  // Pulse: SMI from sleep request.
   input  wire       ringWakeStatus,   // Ring bit of wake status register.
   input  wire       cirWakeStatus,    // Consumer IR bit of wake status.
   input  wire       parallelIrq,      // Parallel port interrupt.
   input  wire       serialTwoIrq,     // Second UART interrupt.
   input  wire       serialOneIrq,     // First UART interrupt.
   input  wire       floppyIrq,        // Floppy interrupt.
   input  wire       gpioGroupBIrq,    // GPIO group B interrupt.
   input  wire       gpioGroupAIrq,    // GPIO group A interrupt.
   input  wire       watchdogIrq,      // Watchdog interrupt.
   input  wire       irqMuxSelect,     // 1 sends SMI to the serial slot.
   input  wire [3:0] dualEdgeInputs,   // Pins for edges, bits 0 to 3.
   input  wire [3:0] dualEdgeIrqMode,  // Dual-edge mode select per pin.
   input  wire [3:0] gpioPolarity,     // Polarity bit per pin.
   input  wire       groupAIrqEnable,  // Group A combined interrupt enable.
   input  wire       groupBIrqEnable,  // Group B combined interrupt enable.
   input  wire       standbyPorPulse,  // Pulse at standby power-on reset.
   input  wire       systemPowerOn_n,  // System power on, active low.
   output wire [3:0] gpioReadBack,     // Data bits seen by GPIO register.
   output wire [3:0] dualEdgeIrq,      // Per-pin dual-edge interrupt.
   output wire       groupAEdgeIrq,    // Dual-edge into group A.
   output wire       groupBEdgeIrq,    // Dual-edge into group B.
   output wire       smiPinOut,        // SMI pin level, active low.
   output wire       smiPinOe,         // SMI pin drive enable.
   output wire       serialIrqTwoReq,  // Request in serial frame slot 2.
   output wire       groupToWakeLogic, // Group SMI into wake logic.
   output reg        acpiControlIrq    // ACPI_CONTROL_IRQ after standby power-on.
);

   wire       group_mgmt_irq_n;
   wire [7:0] statusTwo;
   wire [7:0] miscStatus;
   wire [7:0] enableOneSources;
   wire [7:0] enableTwoSources;
   wire [3:0] edgeChange;
   wire [3:0] edgeSync;
   wire       irChange;
   wire       irSyncUnused;
   wire       groupActive;
   wire       rdStatusTwo;
   wire       wrMisc;

   reg  [7:0] enableOne;
   reg  [7:0] enableTwo;
   reg        infraredEdgeFlag;
   reg        secondaryEventFlag;
   reg        sleepRequestSmiFlag;
   reg  [3:0] dualEdgeFlag;
   reg        standbyPowerOnFlag;
   reg        powerOnLast;
   reg  [3:0] next_dualEdgeFlag;
   reg        next_standby;

   function hit;
      input [4:0] addr;
      input [4:0] offset;
      begin
         hit = (addr == offset);
      end
   endfunction

   assign rdStatusTwo = ioRd & hit(ioAddr, `SMIEG_OFF_STATUS_TWO);
   assign wrMisc      = ioWr & hit(ioAddr, `SMIEG_OFF_MISC_STATUS);

   smieg_edge_sync
   #(
      .WIDTH     (4)
   )
   uEdgeSync
   (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .pinIn     (dualEdgeInputs),
      .pinSync   (edgeSync),
      .pinChange (edgeChange)
   );

   smieg_edge_sync
   #(
      .WIDTH     (1)
   )
   uIrSync
   (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .pinIn     (irRxSelect ? infraredRxIn : serialTwoRxIn),
      .pinSync   (irSyncUnused),
      .pinChange (irChange)
   );

   // Enable registers.
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         enableOne <= `SMIEG_RST_BYTE;
         enableTwo <= `SMIEG_RST_BYTE;
      end
      else
      begin
         if (ioWr && hit(ioAddr, `SMIEG_OFF_ENABLE_ONE))
         begin
            enableOne <= ioWrData;
         end
         if (ioWr && hit(ioAddr, `SMIEG_OFF_ENABLE_TWO))
         begin
            enableTwo <= ioWrData;
         end
      end
   end

   // Read-clear flags of the second status register; a set wins over
   // the clear made by the same read.
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         infraredEdgeFlag    <= 1'b0;
         secondaryEventFlag  <= 1'b0;
         sleepRequestSmiFlag <= 1'b0;
      end
      else
      begin
         infraredEdgeFlag    <= irChange |
                                (infraredEdgeFlag & ~rdStatusTwo);
         secondaryEventFlag  <= secondaryEvent |
                                (secondaryEventFlag & ~rdStatusTwo);
         sleepRequestSmiFlag <= sleepRequestSmi |
                                (sleepRequestSmiFlag & ~rdStatusTwo);
      end
   end

   // Mouse, keyboard and port bits are live views, cleared at the source.
   assign statusTwo = {sleepRequestSmiFlag,
                       2'b00,
                       kbcPortBit,
                       secondaryEventFlag,
                       infraredEdgeFlag,
                       keyboardIrq,
                       mouseIrq};

   // Miscellaneous status: write one clears, edges and reset pulse set.
   always @*
   begin
      next_dualEdgeFlag = dualEdgeFlag;
      next_standby      = standbyPowerOnFlag;
      if (wrMisc)
      begin
         next_dualEdgeFlag = dualEdgeFlag &
                             ~ioWrData[`SMIEG_MS_EDGE_MSB:`SMIEG_MS_EDGE_LSB];
         next_standby      = standbyPowerOnFlag &
                             ~ioWrData[`SMIEG_MS_STANDBY];
      end
      next_dualEdgeFlag = next_dualEdgeFlag | edgeChange;
      next_standby      = next_standby | standbyPorPulse;
   end

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         dualEdgeFlag       <= 4'h0;
         standbyPowerOnFlag <= 1'b0;
         powerOnLast        <= 1'b1;
         acpiControlIrq     <= 1'b0;
      end
      else
      begin
         dualEdgeFlag       <= next_dualEdgeFlag;
         standbyPowerOnFlag <= next_standby;
         powerOnLast        <= systemPowerOn_n;
         // Power coming on while the standby flag stands raises the ACPI_CONTROL_IRQ;
         // it holds until software clears the flag.
         if (standbyPowerOnFlag && powerOnLast && !systemPowerOn_n)
         begin
            acpiControlIrq <= 1'b1;
         end
         else if (!next_standby)
         begin
            acpiControlIrq <= 1'b0;
         end
      end
   end

   assign miscStatus = {3'b000,
                        standbyPowerOnFlag,
                        dualEdgeFlag};

   // Dual-edge outputs need the mode bit and the group enable.
   assign dualEdgeIrq   = dualEdgeFlag & dualEdgeIrqMode &
                          {groupBIrqEnable, groupBIrqEnable,
                           groupAIrqEnable, groupAIrqEnable};
   assign groupAEdgeIrq = dualEdgeIrq[0] | dualEdgeIrq[1];
   assign groupBEdgeIrq = dualEdgeIrq[2] | dualEdgeIrq[3];
   assign gpioReadBack  = edgeSync ^ gpioPolarity;

   // First-register sources are live levels owned by their functions.
   assign enableOneSources = {watchdogIrq,
                              gpioGroupAIrq,
                              gpioGroupBIrq,
                              floppyIrq,
                              serialOneIrq,
                              serialTwoIrq,
                              parallelIrq,
                              ringWakeStatus};
   assign enableTwoSources = {2'b00,
                              cirWakeStatus,
                              kbcPortBit,
                              secondaryEventFlag,
                              infraredEdgeFlag,
                              keyboardIrq,
                              mouseIrq};

   assign groupActive = (|(enableOneSources & enableOne)) |
                        (|(enableTwoSources[5:0] & enableTwo[5:0])) |
                        sleepRequestSmiFlag;
   assign group_mgmt_irq_n = ~groupActive;

   assign groupToWakeLogic = groupActive &
                             enableTwo[`SMIEG_E2_TO_WAKE];
   assign smiPinOut        = group_mgmt_irq_n;
   assign smiPinOe         = enableTwo[`SMIEG_E2_DRIVE] &
                             ~irqMuxSelect;
   assign serialIrqTwoReq  = enableTwo[`SMIEG_E2_DRIVE] & irqMuxSelect &
                             groupActive;

   // Read data register; unmapped offsets read zero.
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ioRdData <= `SMIEG_RST_BYTE;
      end
      else if (ioRd)
      begin
         case (ioAddr)
            `SMIEG_OFF_STATUS_TWO:  ioRdData <= statusTwo;
            `SMIEG_OFF_ENABLE_ONE:  ioRdData <= enableOne;
            `SMIEG_OFF_ENABLE_TWO:  ioRdData <= enableTwo;
            `SMIEG_OFF_MISC_STATUS: ioRdData <= miscStatus;
            default:                ioRdData <= `SMIEG_RST_BYTE;
         endcase
      end
   end

endmodule

`default_nettype wire

// file: smieg_group_irq_sva.sv
`default_nettype none
module smieg_group_irq_sva
(
   input wire logic       clk_sys,          // Clock.
   input wire logic       resetn,           // Reset, active low.
   input wire logic [4:0] ioAddr,           // Offset.
   input wire logic       ioRd,             // Read strobe.
   input wire logic [7:0] ioRdData,         // Read data.
   input wire logic       mouseIrq,         // Mouse level.
   input wire logic       kbcPortBit,       // Port bit level.
   input wire logic       secondaryEvent,   // Set pulse.
   input wire logic       sleepRequestSmi,  // Set pulse.
   input wire logic       irqMuxSelect,     // Pin or slot.
   input wire logic [3:0] dualEdgeIrqMode,  // Modes.
   input wire logic       groupAIrqEnable,  // Group enable.
   input wire logic [3:0] dualEdgeIrq,      // Pin interrupts.
   input wire logic       groupAEdgeIrq,    // Group A out.
   input wire logic       smiPinOut,        // Pin level.
   input wire logic       smiPinOe,         // Pin enable.
   input wire logic       serialIrqTwoReq,  // Slot request.
   input wire logic       groupToWakeLogic  // Wake feed.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence stsRead;
      ioRd && ioAddr == 5'h13;
   endsequence
   sequence readTwice;
      (stsRead and (!secondaryEvent && !sleepRequestSmi)) ##1 stsRead;
   endsequence
   AST_RDCLR: assert property (readTwice |=> !ioRdData[3] && !ioRdData[7])
      else $error("read-clear bits survived a read");
   AST_LIVE: assert property (stsRead |=> ioRdData[0] == $past(mouseIrq)
      && ioRdData[4] == $past(kbcPortBit))
      else $error("status does not follow source levels");
   AST_RSV2: assert property (stsRead |=> ioRdData[6:5] == 2'b00)
      else $error("reserved status bits set");
   AST_RSVM: assert property (ioRd && ioAddr == 5'h16 |=> ioRdData[7:5] == 3'b000)
      else $error("reserved misc bits set");
   AST_HOLD: assert property (!ioRd |=> $stable(ioRdData))
      else $error("read data moved without a read");
   AST_OE: assert property (smiPinOe |-> !irqMuxSelect)
      else $error("pin driven while slot selected");
   AST_SER: assert property (serialIrqTwoReq |-> irqMuxSelect && !smiPinOut)
      else $error("slot request without active group");
   AST_WAKE: assert property (groupToWakeLogic |-> !smiPinOut)
      else $error("wake feed without active group");
   AST_GRPA: assert property (groupAEdgeIrq |-> groupAIrqEnable
      && (dualEdgeIrq[1:0] & ~dualEdgeIrqMode[1:0]) == 2'b00)
      else $error("group A edge irq without enable or mode");
   AST_GRPOR: assert property (dualEdgeIrq[1:0] != 2'b00 |-> groupAEdgeIrq)
      else $error("pin irq missing from group A");
endmodule
`default_nettype wire

// file: smieg_host_model.sv
`default_nettype none
module smieg_host_model
(
   input  wire logic       clk_sys,  // Clock.
   input  wire logic [7:0] ioRdData, // Read data.
   output var  logic [4:0] ioAddr,   // Offset.
   output var  logic       ioRd,     // Read strobe.
   output var  logic       ioWr,     // Write strobe.
   output var  logic [7:0] ioWrData  // Write data.
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {ioAddr, ioRd, ioWr, ioWrData} = '0;
   end
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      ioAddr = a;
      ioWrData = d;
      ioWr = 1'b1;
      @(posedge clk_sys);
      #1;
      ioWr = 1'b0;
      ioWrData = ~d;
   endtask
   // Holds the strobe for n back-to-back reads; returns first and last.
   task automatic rd(input logic [4:0] a, input int n,
                     output logic [7:0] d0, output logic [7:0] d1);
      @(posedge clk_sys);
      #1;
      ioAddr = a;
      ioRd = 1'b1;
      @(posedge clk_sys);
      #1;
      d0 = ioRdData;
      repeat (n - 1) @(posedge clk_sys);
      #1;
      ioRd = 1'b0;
      d1 = ioRdData;
   endtask
endmodule
`default_nettype wire

// file: tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, resetn, mouseIrq, keyboardIrq, kbcPortBit, infraredRxIn;
   logic irRxSelect, secondaryEvent, sleepRequestSmi, cirWakeStatus;
   logic irqMuxSelect, groupAIrqEnable, groupBIrqEnable, standbyPorPulse;
   logic systemPowerOn_n, serialTwoRxIn;
   logic [7:0] srcOne, r0, r1;
   logic [3:0] dualEdgeInputs, dualEdgeIrqMode, gpioPolarity;
   wire logic [4:0] ioAddr;
   wire logic [7:0] ioWrData, ioRdData;
   wire logic [3:0] gpioReadBack, dualEdgeIrq;
   wire logic ioRd, ioWr, groupAEdgeIrq, groupBEdgeIrq, smiPinOut, smiPinOe;
   wire logic serialIrqTwoReq, groupToWakeLogic, acpiControlIrq;
   int num_errors, samples_checked;
   smieg_host_model host (.clk_sys, .ioRdData, .ioAddr, .ioRd, .ioWr,
      .ioWrData);
   smieg_group_irq uut (.clk_sys, .resetn, .ioAddr, .ioRd, .ioWr, .ioWrData,
      .ioRdData, .mouseIrq, .keyboardIrq, .kbcPortBit, .serialTwoRxIn,
      .infraredRxIn, .irRxSelect, .secondaryEvent, .sleepRequestSmi,
      .ringWakeStatus(srcOne[0]), .cirWakeStatus, .parallelIrq(srcOne[1]),
      .serialTwoIrq(srcOne[2]), .serialOneIrq(srcOne[3]),
      .floppyIrq(srcOne[4]), .gpioGroupBIrq(srcOne[5]),
      .gpioGroupAIrq(srcOne[6]), .watchdogIrq(srcOne[7]), .irqMuxSelect,
      .dualEdgeInputs, .dualEdgeIrqMode, .gpioPolarity, .groupAIrqEnable,
      .groupBIrqEnable, .standbyPorPulse, .systemPowerOn_n, .gpioReadBack,
      .dualEdgeIrq, .groupAEdgeIrq, .groupBEdgeIrq, .smiPinOut, .smiPinOe,
      .serialIrqTwoReq, .groupToWakeLogic, .acpiControlIrq);
   initial clk_sys = 1'b0;
   always #20 clk_sys = ~clk_sys;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wrChk(input logic [4:0] a, input logic [7:0] d,
                        input logic [7:0] exp);
      host.wr(a, d);
      host.rd(a, 1, r0, r1);
      chk(r0, exp);
   endtask
   task summarize;
      $display("Checked %0d values, %0d mismatches", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task testRegs;
      for (int a = 5'h13; a <= 5'h16; a++)
      begin
         host.rd(5'(a), 1, r0, r1);
         chk(r0, 8'h00);
      end
      wrChk(5'h00, 8'hFF, 8'h00);
      wrChk(5'h14, 8'hA5, 8'hA5);
      wrChk(5'h15, 8'h5A, 8'h5A);
      host.wr(5'h14, 8'h00);
      host.wr(5'h15, 8'h00);
      $display("testRegs done");
   endtask
   task testStatus;
      {mouseIrq, keyboardIrq, kbcPortBit, infraredRxIn} = 4'hF;
      {secondaryEvent, sleepRequestSmi} = 2'b11;
      tick(1);
      {secondaryEvent, sleepRequestSmi} = 2'b00;
      tick(5);
      host.rd(5'h13, 2, r0, r1);
      chk(r0, 8'h9F);
      chk(r1, 8'h13);
      {mouseIrq, keyboardIrq, kbcPortBit} = 3'b000;
      host.rd(5'h13, 1, r0, r1);
      chk(r0, 8'h00);
      // Switching the mux from a high to a low pin is itself a transition.
      irRxSelect = 1'b0;
      tick(5);
      host.rd(5'h13, 1, r0, r1);
      chk(r0, 8'h04);
      serialTwoRxIn = 1'b1;
      tick(5);
      host.rd(5'h13, 2, r0, r1);
      chk(r0, 8'h04);
      chk(r1, 8'h00);
      $display("testStatus done");
   endtask
   task testGate;
      logic [7:0] gates [4] = '{8'h81, 8'h82, 8'h90, 8'hA0};
      for (int i = 0; i < 8; i++)
      begin
         wrChk(5'h14, 8'h01 << i, 8'h01 << i);
         srcOne = ~(8'h01 << i);
         tick(1);
         chk({7'h00, smiPinOut}, 8'h01);
         srcOne = 8'h01 << i;
         tick(1);
         chk({7'h00, smiPinOut}, 8'h00);
      end
      srcOne = 8'h00;
      host.wr(5'h14, 8'h00);
      {mouseIrq, keyboardIrq, kbcPortBit, cirWakeStatus} = 4'hF;
      host.wr(5'h15, 8'h80);
      chk({6'h00, smiPinOe, smiPinOut}, 8'h03);
      for (int i = 0; i < 4; i++)
      begin
         host.wr(5'h15, gates[i]);
         chk({7'h00, smiPinOut}, 8'h00);
      end
      irqMuxSelect = 1'b1;
      host.wr(5'h15, 8'hC2);
      chk({smiPinOe, serialIrqTwoReq, groupToWakeLogic}, 8'h03);
      host.wr(5'h15, 8'h02);
      chk({smiPinOe, serialIrqTwoReq, groupToWakeLogic}, 8'h00);
      {mouseIrq, keyboardIrq, kbcPortBit, cirWakeStatus, irqMuxSelect} = 5'h00;
      $display("testGate done");
   endtask
   task testEdges;
      {dualEdgeIrqMode, gpioPolarity, groupAIrqEnable} = {8'hF5, 1'b1};
      dualEdgeInputs = 4'hF;
      tick(5);
      wrChk(5'h16, 8'h00, 8'h0F);
      chk({dualEdgeIrq, 2'b00, groupBEdgeIrq, groupAEdgeIrq}, 8'h31);
      chk({4'h0, gpioReadBack}, 8'h0A);
      wrChk(5'h16, 8'h05, 8'h0A);
      host.wr(5'h16, 8'h0F);
      {groupBIrqEnable, dualEdgeIrqMode, dualEdgeInputs} = {1'b1, 8'h70};
      tick(5);
      wrChk(5'h16, 8'h00, 8'h0F);
      chk({dualEdgeIrq, 2'b00, groupBEdgeIrq, groupAEdgeIrq}, 8'h73);
      host.wr(5'h16, 8'h0F);
      $display("testEdges done");
   endtask
   task testStandby;
      standbyPorPulse = 1'b1;
      tick(1);
      standbyPorPulse = 1'b0;
      host.rd(5'h16, 1, r0, r1);
      chk(r0, 8'h10);
      systemPowerOn_n = 1'b0;
      tick(3);
      chk({7'h00, acpiControlIrq}, 8'h01);
      wrChk(5'h16, 8'h10, 8'h00);
      chk({7'h00, acpiControlIrq}, 8'h00);
      systemPowerOn_n = 1'b1;
      $display("testStandby done");
   endtask
   initial
   begin
      {mouseIrq, keyboardIrq, kbcPortBit, infraredRxIn, secondaryEvent} = '0;
      {sleepRequestSmi, cirWakeStatus, irqMuxSelect, groupAIrqEnable} = '0;
      {groupBIrqEnable, standbyPorPulse, srcOne, dualEdgeInputs} = '0;
      {dualEdgeIrqMode, gpioPolarity, num_errors, samples_checked} = '0;
      {resetn, irRxSelect, systemPowerOn_n, serialTwoRxIn} = 4'b0110;
      repeat (20) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      testRegs();
      testStatus();
      testGate();
      testEdges();
      testStandby();
      summarize();
   end
   initial
   begin
      #200000;
      num_errors++;
      summarize();
   end
endmodule
bind smieg_group_irq smieg_group_irq_sva chk (.clk_sys, .resetn, .ioAddr,
   .ioRd, .ioRdData, .mouseIrq, .kbcPortBit, .secondaryEvent,
   .sleepRequestSmi, .irqMuxSelect, .dualEdgeIrqMode, .groupAIrqEnable,
   .dualEdgeIrq, .groupAEdgeIrq, .smiPinOut, .smiPinOe, .serialIrqTwoReq,
   .groupToWakeLogic);
`default_nettype wire
